//--- verilog/crf_pkg.sv
// package: register file, status flag and bus map constants
package crf_pkg;
	localparam int NREGS = 32;
	localparam int DW = 8;
	localparam int RAW = 5;
	// status flag bit positions
	localparam int SF_I = 7;
	localparam int SF_T = 6;
	localparam int SF_H = 5;
	localparam int SF_S = 4;
	localparam int SF_V = 3;
	localparam int SF_N = 2;
	localparam int SF_Z = 1;
	localparam int SF_C = 0;
	localparam logic [7:0] SF_RESET = 8'h00;
	// pointer pair base register numbers
	localparam logic [4:0] PTR_X = 5'h1a;
	localparam logic [4:0] PTR_Y = 5'h1c;
	localparam logic [4:0] PTR_Z = 5'h1e;
	// data space map
	localparam logic [15:0] DS_REG_LAST = 16'h001f;
	localparam logic [15:0] DS_IO_FIRST = 16'h0020;
	localparam logic [15:0] DS_IO_LAST = 16'h005f;
	localparam int IO_SIZE = 64;
	// apb map: status word, pointer words, then register file words
	localparam logic [11:0] A_STATUS = 12'h000;
	localparam logic [11:0] A_PTRS = 12'h004;
	localparam logic [11:0] A_IRQ = 12'h008;
	localparam logic [11:0] A_RF_BASE = 12'h080;
	localparam logic [11:0] A_RF_LAST = 12'h0fc;

	typedef enum logic [3:0] {
		CRF_ADD, CRF_ADC, CRF_SUB, CRF_SBC, CRF_AND, CRF_OR, CRF_EOR,
		CRF_COM, CRF_NEG, CRF_INC, CRF_DEC, CRF_MOV, CRF_LSR, CRF_ADIW,
		CRF_NOP
	} crf_alu_op_t;

	typedef enum logic [2:0] {
		CRF_SF_NONE, CRF_SF_SEI, CRF_SF_CLI, CRF_SF_BST, CRF_SF_BLD,
		CRF_SF_INTERRUPT_RETURN_OP
	} crf_sf_op_t;

	typedef struct packed {
		logic valid;
		crf_alu_op_t op;
		crf_sf_op_t sf_op;
		logic use_imm;
		logic [7:0] imm;
		logic [4:0] rd;
		logic [4:0] rr;
		logic [2:0] bitsel;
		logic wide;
	} crf_instr_t;
endpackage

//--- verilog/crf_core.sv
// core register file, alu writeback, status flags and pointers
//
// Contract
// - fetch next instruction while current executes
// - 32 registers, 8 bits, single-cycle access
// - read two operands, write result same cycle
// - registers 0x1a-0x1f form three pointers
// - z pointer addresses flash lookup tables
// - alu ops register-register, immediate, single operand
// - flags updated after every alu operation except mov
// - status not saved or restored on interrupt
// - bit 7 zero blocks every interrupt
// - interrupt taken clears, return sets, bit 7
// - set and clear enable instructions
// - bit 6 copy store for bit ops
// - bit 5 half carry from nibble
// - bit 4 sign equals n xor v
// - bit 3 two's complement overflow
// - bit 2 negative result
// - bit 1 zero result
// - bit 0 carry
// - four read/write port schemes supported; the core has three, adiw being its only 16-bit result
// - registers mapped at data 0x00-0x1f
// - io space 64 at data 0x20-0x5f
// - lowest vector pending interrupt served first
//
// The register addresses and the APB register port were left to the implementer.
module crf_core
	import crf_pkg::*;
#(
	parameter int NIRQ = 8,
	parameter int PAW = 16
) (
	input wire logic i_clk,
	input wire logic i_rst,
	// program fetch
	output logic [PAW-1:0] o_fetch_addr,
	input wire logic [15:0] i_fetch_data,
	input wire logic i_advance,
	output logic [15:0] o_instr_word,
	// decoded instruction
	input wire crf_instr_t i_instr,
	// data space access
	input wire logic i_ds_rd,
	input wire logic i_ds_wr,
	input wire logic [15:0] i_ds_addr,
	input wire logic [7:0] i_ds_wdata,
	output logic [7:0] o_ds_rdata,
	output logic o_ds_is_io,
	output logic [5:0] o_io_addr,
	// pointers
	output logic [15:0] o_ptr_x,
	output logic [15:0] o_ptr_y,
	output logic [15:0] o_ptr_z,
	output logic [15:0] o_lpm_addr,
	// interrupts
	input wire logic [NIRQ-1:0] i_irq_pend,
	output logic o_irq_take,
	output logic [$clog2(NIRQ)-1:0] o_irq_num,
	// status
	output logic [7:0] o_status_flags,
	// apb
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr
);
	////////////////////////////////////////////////////////////////////////
	logic [7:0] regs [NREGS];
	logic [7:0] status_flags_reg;
	logic [15:0] instr_reg;
	logic [PAW-1:0] pc_reg;
	logic [7:0] op_a;
	logic [7:0] op_b;
	logic [7:0] res;
	logic [7:0] res_hi;
	logic [7:0] flags_next;
	logic wr_en;
	logic wr_wide;
	logic irq_any;
	logic apb_wr;
	logic apb_rf_wr;
	logic [4:0] apb_idx;
	localparam int IRQW = $clog2(NIRQ);

	// bytes come in as arguments so the pointer assigns follow every write
	function automatic logic [15:0] pair(input logic [7:0] lo,
		input logic [7:0] hi);
		pair = {hi, lo};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// fetch overlaps execution: next word is registered while current runs
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pc_reg <= '0;
			instr_reg <= 16'h0000;
		end else if (i_advance) begin
			pc_reg <= pc_reg + PAW'(1);
			instr_reg <= i_fetch_data;
		end
	end
	assign o_fetch_addr = pc_reg;
	assign o_instr_word = instr_reg;

	////////////////////////////////////////////////////////////////////////
	// combinational operand read, one write port per cycle
	assign op_a = regs[i_instr.rd];
	assign op_b = i_instr.use_imm ? i_instr.imm : regs[i_instr.rr];

	always_comb begin
		logic [8:0] sum;
		logic [16:0] w;
		logic cin;
		sum = 9'h000;
		w = 17'h00000;
		cin = status_flags_reg[SF_C];
		res = op_a;
		res_hi = 8'h00;
		flags_next = status_flags_reg;
		wr_en = i_instr.valid;
		wr_wide = 1'b0;
		case (i_instr.op)
		CRF_ADD, CRF_ADC: begin
			sum = {1'b0, op_a} + {1'b0, op_b} +
				{8'h00, (i_instr.op == CRF_ADC) & cin};
			res = sum[7:0];
			flags_next[SF_C] = sum[8];
			flags_next[SF_H] = (op_a[3] & op_b[3]) | (op_b[3] & ~res[3]) |
				(~res[3] & op_a[3]);
			flags_next[SF_V] = (op_a[7] & op_b[7] & ~res[7]) |
				(~op_a[7] & ~op_b[7] & res[7]);
		end
		CRF_SUB, CRF_SBC: begin
			sum = {1'b0, op_a} - {1'b0, op_b} -
				{8'h00, (i_instr.op == CRF_SBC) & cin};
			res = sum[7:0];
			flags_next[SF_C] = sum[8];
			flags_next[SF_H] = (~op_a[3] & op_b[3]) | (op_b[3] & res[3]) |
				(res[3] & ~op_a[3]);
			flags_next[SF_V] = (op_a[7] & ~op_b[7] & ~res[7]) |
				(~op_a[7] & op_b[7] & res[7]);
		end
		CRF_AND, CRF_OR, CRF_EOR: begin
			res = (i_instr.op == CRF_AND) ? (op_a & op_b) :
				(i_instr.op == CRF_OR) ? (op_a | op_b) : (op_a ^ op_b);
			flags_next[SF_V] = 1'b0;
		end
		CRF_COM: begin
			res = ~op_a;
			flags_next[SF_V] = 1'b0;
			flags_next[SF_C] = 1'b1;
		end
		CRF_NEG: begin
			res = 8'h00 - op_a;
			flags_next[SF_C] = (res != 8'h00);
			flags_next[SF_V] = (res == 8'h80);
			flags_next[SF_H] = res[3] | op_a[3];
		end
		CRF_INC, CRF_DEC: begin
			res = (i_instr.op == CRF_INC) ? op_a + 8'h01 : op_a - 8'h01;
			flags_next[SF_V] = (i_instr.op == CRF_INC) ?
				(op_a == 8'h7f) : (op_a == 8'h80);
		end
		CRF_LSR: begin
			res = {1'b0, op_a[7:1]};
			flags_next[SF_C] = op_a[0];
			flags_next[SF_V] = op_a[0];
		end
		CRF_ADIW: begin
			// two 8-bit reads of the pair, one 16-bit result written back
			w = {1'b0, regs[i_instr.rd + 5'd1], op_a} +
				{11'h000, i_instr.imm[5:0]};
			res = w[7:0];
			res_hi = w[15:8];
			wr_wide = 1'b1;
			flags_next[SF_C] = w[16];
			flags_next[SF_V] = ~regs[i_instr.rd + 5'd1][7] & w[15];
		end
		CRF_MOV: begin
			res = op_b;
		end
		default: begin
			wr_en = 1'b0;
		end
		endcase
		if (i_instr.op != CRF_MOV && i_instr.op != CRF_NOP) begin
			flags_next[SF_N] = wr_wide ? res_hi[7] : res[7];
			flags_next[SF_Z] = wr_wide ? ({res_hi, res} == 16'h0000) :
				(res == 8'h00);
			flags_next[SF_S] = flags_next[SF_N] ^ flags_next[SF_V];
		end
		if (i_instr.sf_op == CRF_SF_BLD) begin
			res = op_a;
			res[i_instr.bitsel] = status_flags_reg[SF_T];
			wr_en = i_instr.valid;
		end
		if (!i_instr.valid) begin
			flags_next = status_flags_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb decode, zero wait states
	assign o_pready = 1'b1;
	assign apb_wr = i_psel & i_penable & i_pwrite;
	assign apb_rf_wr = apb_wr & (i_paddr >= A_RF_BASE) &
		(i_paddr <= A_RF_LAST) & (i_paddr[1:0] == 2'b00);
	assign apb_idx = i_paddr[6:2];
	assign o_pslverr = i_psel & i_penable &
		!((i_paddr == A_STATUS) || (i_paddr == A_PTRS) ||
		(i_paddr == A_IRQ) || ((i_paddr >= A_RF_BASE) &&
		(i_paddr <= A_RF_LAST) && (i_paddr[1:0] == 2'b00)));

	always_comb begin
		o_prdata = 32'h00000000;
		if (i_paddr == A_STATUS) begin
			o_prdata = {24'h000000, status_flags_reg};
		end else if (i_paddr == A_PTRS) begin
			o_prdata = {o_ptr_y, o_ptr_x};
		end else if (i_paddr == A_IRQ) begin
			o_prdata = {16'h0000, o_ptr_z};
		end else if (i_paddr >= A_RF_BASE && i_paddr <= A_RF_LAST) begin
			o_prdata = {24'h000000, regs[apb_idx]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register file write: alu result, data space store, then apb
	logic ds_reg_hit;
	assign ds_reg_hit = i_ds_addr <= DS_REG_LAST;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int k = 0; k < NREGS; k++) begin
				regs[k] <= 8'h00;
			end
		end else if (wr_en) begin
			regs[i_instr.rd] <= res;
			if (wr_wide) begin
				regs[i_instr.rd + 5'd1] <= res_hi;
			end
		end else if (i_ds_wr && ds_reg_hit) begin
			regs[i_ds_addr[4:0]] <= i_ds_wdata;
		end else if (apb_rf_wr) begin
			regs[apb_idx] <= i_pwdata[7:0];
		end
	end

	assign o_ds_rdata = (i_ds_rd && ds_reg_hit) ? regs[i_ds_addr[4:0]] :
		8'h00;
	assign o_ds_is_io = (i_ds_addr >= DS_IO_FIRST) &&
		(i_ds_addr <= DS_IO_LAST);
	assign o_io_addr = 6'(i_ds_addr - DS_IO_FIRST);

	assign o_ptr_x = pair(regs[PTR_X], regs[PTR_X + 5'd1]);
	assign o_ptr_y = pair(regs[PTR_Y], regs[PTR_Y + 5'd1]);
	assign o_ptr_z = pair(regs[PTR_Z], regs[PTR_Z + 5'd1]);
	assign o_lpm_addr = o_ptr_z;

	////////////////////////////////////////////////////////////////////////
	// interrupt pick: lowest index is lowest vector address
	always_comb begin
		o_irq_num = '0;
		for (int k = NIRQ - 1; k >= 0; k--) begin
			if (i_irq_pend[k]) begin
				o_irq_num = IRQW'(k);
			end
		end
	end
	assign irq_any = |i_irq_pend;
	// gated by the enable; a cli in flight also blocks the take
	assign o_irq_take = irq_any & status_flags_reg[SF_I] &
		!(i_instr.valid && i_instr.sf_op == CRF_SF_CLI);

	////////////////////////////////////////////////////////////////////////
	// status flags; no shadow copy is kept for interrupt entry
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			status_flags_reg <= SF_RESET;
		end else if (apb_wr && i_paddr == A_STATUS) begin
			status_flags_reg <= i_pwdata[7:0];
		end else begin
			status_flags_reg <= flags_next;
			if (i_instr.valid) begin
				case (i_instr.sf_op)
				CRF_SF_SEI: status_flags_reg[SF_I] <= 1'b1;
				CRF_SF_CLI: status_flags_reg[SF_I] <= 1'b0;
				CRF_SF_INTERRUPT_RETURN_OP: status_flags_reg[SF_I] <= 1'b1;
				CRF_SF_BST: status_flags_reg[SF_T] <=
					op_a[i_instr.bitsel];
				default: ;
				endcase
			end
			if (o_irq_take) begin
				status_flags_reg[SF_I] <= 1'b0;
			end
		end
	end
	assign o_status_flags = status_flags_reg;

	////////////////////////////////////////////////////////////////////////
	property p_sign;
		@(posedge i_clk) disable iff (i_rst)
		o_status_flags[SF_S] == (o_status_flags[SF_N] ^ o_status_flags[SF_V])
		|| $past(apb_wr);
	endproperty
	a_sign: assert property (p_sign)
		else $error("sign flag mismatch");

	property p_take_clears;
		@(posedge i_clk) disable iff (i_rst)
		o_irq_take && !apb_wr |=> !o_status_flags[SF_I];
	endproperty
	a_take_clears: assert property (p_take_clears)
		else $error("enable not cleared on take");

	property p_no_take;
		@(posedge i_clk) disable iff (i_rst)
		!o_status_flags[SF_I] |-> !o_irq_take;
	endproperty
	a_no_take: assert property (p_no_take)
		else $error("interrupt taken while disabled");

	property p_zero;
		@(posedge i_clk) disable iff (i_rst)
		i_instr.valid && i_instr.op == CRF_AND && !apb_wr &&
		i_instr.sf_op == CRF_SF_NONE && !o_irq_take
		|=> o_status_flags[SF_Z] == (regs[$past(i_instr.rd)] == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	logic [8:0] sum_chk;
	assign sum_chk = {1'b0, op_a} + {1'b0, op_b};
	property p_add_carry;
		@(posedge i_clk) disable iff (i_rst)
		i_instr.valid && i_instr.op == CRF_ADD && !apb_wr
		|=> o_status_flags[SF_C] == $past(sum_chk[8]);
	endproperty
	a_add_carry: assert property (p_add_carry)
		else $error("carry flag wrong");

	property p_sei;
		@(posedge i_clk) disable iff (i_rst)
		i_instr.valid && i_instr.sf_op == CRF_SF_SEI && !o_irq_take &&
		!apb_wr |=> o_status_flags[SF_I];
	endproperty
	a_sei: assert property (p_sei) else $error("sei did not set");

	property p_ptr_z;
		@(posedge i_clk) disable iff (i_rst)
		o_lpm_addr == {regs[5'h1f], regs[5'h1e]};
	endproperty
	a_ptr_z: assert property (p_ptr_z)
		else $error("z pointer wrong");

	property p_io_map;
		@(posedge i_clk) disable iff (i_rst)
		(i_ds_addr == 16'h0020) |-> o_ds_is_io && o_io_addr == 6'h00;
	endproperty
	a_io_map: assert property (p_io_map) else $error("io map wrong");

	property p_wb;
		@(posedge i_clk) disable iff (i_rst)
		i_instr.valid && i_instr.op == CRF_MOV && i_instr.use_imm &&
		i_instr.sf_op == CRF_SF_NONE |=> regs[$past(i_instr.rd)] ==
		$past(i_instr.imm);
	endproperty
	a_wb: assert property (p_wb) else $error("writeback missing");

	c_irq: cover property (@(posedge i_clk) disable iff (i_rst) o_irq_take);
	c_adiw: cover property (@(posedge i_clk) disable iff (i_rst)
		i_instr.valid && i_instr.op == CRF_ADIW);
	c_bld: cover property (@(posedge i_clk) disable iff (i_rst)
		i_instr.valid && i_instr.sf_op == CRF_SF_BLD);
endmodule

//--- testbench/test_cpu_register_file_and_status.sv
// self-checking bench for the register file, alu flags and pointer block
module test_cpu_register_file_and_status import crf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIMIT = 5000;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [15:0] i_fetch_data = 16'h0000;
	logic i_advance = 1'b0;
	crf_instr_t i_instr = '0;
	logic i_ds_rd = 1'b0;
	logic i_ds_wr = 1'b0;
	logic [15:0] i_ds_addr = 16'h0000;
	logic [7:0] i_ds_wdata = 8'h00;
	logic [7:0] i_irq_pend = 8'h00;
	logic i_psel = 1'b0;
	logic i_penable = 1'b0;
	logic i_pwrite = 1'b0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0;
	wire [15:0] o_fetch_addr, o_instr_word, o_ptr_x, o_ptr_y, o_ptr_z;
	wire [15:0] o_lpm_addr;
	wire [7:0] o_ds_rdata, o_status_flags;
	wire [5:0] o_io_addr;
	wire [2:0] o_irq_num;
	wire [31:0] o_prdata;
	wire o_ds_is_io, o_irq_take, o_pready, o_pslverr;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic err;

	crf_core #(.NIRQ(8), .PAW(16)) dut (.i_clk(i_clk), .i_rst(i_rst),
		.o_fetch_addr(o_fetch_addr), .i_fetch_data(i_fetch_data),
		.i_advance(i_advance), .o_instr_word(o_instr_word),
		.i_instr(i_instr), .i_ds_rd(i_ds_rd), .i_ds_wr(i_ds_wr),
		.i_ds_addr(i_ds_addr), .i_ds_wdata(i_ds_wdata),
		.o_ds_rdata(o_ds_rdata), .o_ds_is_io(o_ds_is_io),
		.o_io_addr(o_io_addr), .o_ptr_x(o_ptr_x), .o_ptr_y(o_ptr_y),
		.o_ptr_z(o_ptr_z), .o_lpm_addr(o_lpm_addr),
		.i_irq_pend(i_irq_pend), .o_irq_take(o_irq_take),
		.o_irq_num(o_irq_num), .o_status_flags(o_status_flags),
		.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
		.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr));

	always #2 i_clk = ~i_clk;

	////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// a hung handshake would otherwise stall the run forever
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			num_errors++;
			$display("unexpected at %0t: timeout", $time);
			complete_run();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		do
			@(posedge i_clk);
		while (o_pready !== 1'b1);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask

	task automatic exec(input crf_alu_op_t op, input crf_sf_op_t sf,
		input logic imm_sel, input logic [7:0] imm, input logic [4:0] d,
		input logic [4:0] r, input logic [2:0] b);
		@(posedge i_clk);
		i_instr <= '{1'b1, op, sf, imm_sel, imm, d, r, b, 1'b0};
		@(posedge i_clk);
		i_instr.valid <= 1'b0;
		@(negedge i_clk);
	endtask

	task automatic ds_check(input logic [15:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_ds_rd <= 1'b1;
		i_ds_addr <= a;
		@(negedge i_clk);
		check({24'h0, o_ds_rdata}, {24'h0, exp});
		@(posedge i_clk);
		i_ds_rd <= 1'b0;
	endtask

	// operands go to r16 and r17, the result is read back from r16
	task automatic alu_case(input crf_alu_op_t op, input logic imm_sel,
		input logic [7:0] a, input logic [7:0] b, input logic [7:0] res,
		input logic [7:0] fl, input logic [7:0] mask);
		apb(1'b1, A_RF_BASE + 12'h040, {24'h0, a});
		apb(1'b1, A_RF_BASE + 12'h044, {24'h0, b});
		exec(op, CRF_SF_NONE, imm_sel, b, 5'h10, 5'h11, 3'h0);
		ds_check(16'h0010, res);
		check({24'h0, o_status_flags & mask}, {24'h0, fl});
		check({31'h0, o_status_flags[SF_S]},
			{31'h0, o_status_flags[SF_N] ^ o_status_flags[SF_V]});
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		apb(1'b0, A_STATUS, 32'h0);
		check(rd, 32'h0);
		check({31'h0, err}, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		check({31'h0, err}, 32'h1);
		apb(1'b0, 12'h081, 32'h0);
		check({31'h0, err}, 32'h1);
		apb(1'b1, 12'h081, 32'h5a);
		check({31'h0, err}, 32'h1);
		apb(1'b0, A_RF_BASE, 32'h0);
		check(rd, 32'h0);
		end_test("reset_map");
		for (int n = 26; n < 32; n++)
			apb(1'b1, A_RF_BASE + 12'(4 * n), 32'(n));
		@(negedge i_clk);
		check({16'h0, o_ptr_x}, 32'h1b1a);
		check({16'h0, o_ptr_y}, 32'h1d1c);
		check({16'h0, o_lpm_addr}, 32'h1f1e);
		check({16'h0, o_ptr_z}, 32'h1f1e);
		apb(1'b0, A_PTRS, 32'h0);
		check(rd, 32'h1d1c1b1a);
		apb(1'b0, A_IRQ, 32'h0);
		check(rd, 32'h00001f1e);
		apb(1'b1, A_RF_BASE + 12'h068, 32'hff);
		apb(1'b1, A_RF_BASE + 12'h06c, 32'h00);
		exec(CRF_ADIW, CRF_SF_NONE, 1'b1, 8'h01, 5'h1a, 5'h00, 3'h0);
		check({16'h0, o_ptr_x}, 32'h0100);
		end_test("pointers");
		alu_case(CRF_ADD, 1'b0, 8'h80, 8'h80, 8'h00, 8'h1b, 8'h3f);
		alu_case(CRF_ADD, 1'b0, 8'h0f, 8'h01, 8'h10, 8'h20, 8'h3f);
		alu_case(CRF_SUB, 1'b1, 8'h00, 8'h01, 8'hff, 8'h35, 8'h3f);
		alu_case(CRF_AND, 1'b0, 8'hf0, 8'h0f, 8'h00, 8'h02, 8'h1e);
		alu_case(CRF_INC, 1'b0, 8'h7f, 8'h00, 8'h80, 8'h0c, 8'h1e);
		alu_case(CRF_EOR, 1'b0, 8'hff, 8'h7f, 8'h80, 8'h14, 8'h1e);
		// carry is set here, so the subtract below borrows one more
		alu_case(CRF_SBC, 1'b0, 8'h10, 8'h01, 8'h0e, 8'h20, 8'h3f);
		alu_case(CRF_COM, 1'b0, 8'h0f, 8'h00, 8'hf0, 8'h15, 8'h1f);
		alu_case(CRF_ADC, 1'b0, 8'h10, 8'h20, 8'h31, 8'h00, 8'h3f);
		alu_case(CRF_NEG, 1'b0, 8'h01, 8'h00, 8'hff, 8'h35, 8'h3f);
		alu_case(CRF_DEC, 1'b0, 8'h80, 8'h00, 8'h7f, 8'h18, 8'h1e);
		alu_case(CRF_LSR, 1'b0, 8'h01, 8'h00, 8'h00, 8'h1b, 8'h1f);
		alu_case(CRF_OR, 1'b0, 8'h00, 8'h00, 8'h00, 8'h02, 8'h1e);
		// a move leaves every flag as the previous operation set it
		alu_case(CRF_MOV, 1'b1, 8'h33, 8'h5a, 8'h5a, 8'h23, 8'h3f);
		end_test("alu_flags");
		apb(1'b1, A_RF_BASE + 12'h040, 32'h08);
		apb(1'b1, A_RF_BASE + 12'h048, 32'h00);
		apb(1'b1, A_STATUS, 32'h00);
		exec(CRF_NOP, CRF_SF_BST, 1'b0, 8'h00, 5'h10, 5'h00, 3'h3);
		check({24'h0, o_status_flags}, 32'h40);
		exec(CRF_NOP, CRF_SF_BLD, 1'b0, 8'h00, 5'h12, 5'h00, 3'h0);
		ds_check(16'h0012, 8'h01);
		end_test("bit_copy");
		apb(1'b1, A_STATUS, 32'h55);
		exec(CRF_NOP, CRF_SF_SEI, 1'b0, 8'h00, 5'h00, 5'h00, 3'h0);
		check({24'h0, o_status_flags}, 32'hd5);
		@(posedge i_clk);
		i_irq_pend <= 8'h28;
		@(negedge i_clk);
		check({31'h0, o_irq_take}, 32'h1);
		check({29'h0, o_irq_num}, 32'h3);
		@(posedge i_clk);
		@(negedge i_clk);
		check({24'h0, o_status_flags}, 32'h55);
		check({31'h0, o_irq_take}, 32'h0);
		@(posedge i_clk);
		i_irq_pend <= 8'h00;
		exec(CRF_NOP, CRF_SF_INTERRUPT_RETURN_OP, 1'b0, 8'h00, 5'h00, 5'h00, 3'h0);
		check({24'h0, o_status_flags}, 32'hd5);
		exec(CRF_NOP, CRF_SF_CLI, 1'b0, 8'h00, 5'h00, 5'h00, 3'h0);
		check({24'h0, o_status_flags}, 32'h55);
		apb(1'b0, A_STATUS, 32'h0);
		check(rd, 32'h55);
		end_test("interrupt_enable");
		@(posedge i_clk);
		i_fetch_data <= 16'hbeef;
		i_advance <= 1'b1;
		i_ds_wr <= 1'b1;
		i_ds_addr <= 16'h0005;
		i_ds_wdata <= 8'ha5;
		@(posedge i_clk);
		i_advance <= 1'b0;
		i_ds_wr <= 1'b0;
		@(negedge i_clk);
		check({16'h0, o_instr_word}, 32'hbeef);
		check({16'h0, o_fetch_addr}, 32'h0001);
		ds_check(16'h0005, 8'ha5);
		apb(1'b0, A_RF_BASE + 12'h014, 32'h0);
		check(rd, 32'ha5);
		ds_check(16'h001f, 8'h1f);
		check({31'h0, o_ds_is_io}, 32'h0);
		ds_check(16'h0020, 8'h00);
		check({31'h0, o_ds_is_io}, 32'h1);
		ds_check(16'h005f, 8'h00);
		check({26'h0, o_io_addr}, 32'h3f);
		ds_check(16'h0060, 8'h00);
		check({31'h0, o_ds_is_io}, 32'h0);
		end_test("fetch_data_space");
		complete_run();
	end
endmodule
